// [hdl/ms_delay_timer.v]
// millisecond delay timer used by the brake sequence
`timescale 1ns/100ps
module ms_delay_timer #(
    parameter MS_CYCLES = 100000
) (
    input wire sys_clk,
    input wire rst_b,
    input wire run,
    input wire [15:0] delayMs,
    output wire done
);
    reg [31:0] tickCount;
    reg [15:0] msCount;
    wire msTick;

    assign msTick = (tickCount == MS_CYCLES - 1);
    // a zero delay finishes at once, with no millisecond tick needed
    assign done = run && (msCount >= delayMs);

    always @(posedge sys_clk) begin
        if (!rst_b || !run) begin
            tickCount <= 32'h0000_0000;
            msCount <= 16'h0000;
        end else if (!done) begin
            if (msTick) begin
                tickCount <= 32'h0000_0000;
                msCount <= msCount + 16'h0001;
            end else begin
                tickCount <= tickCount + 32'h0000_0001;
            end
        end
    end
endmodule

// [hdl/servo_config_parameter_bank.v]
// servo amplifier configuration parameter bank with an AXI4-Lite slave
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "servo_param_defs.vh"
module servo_config_parameter_bank #(
    parameter ADDR_WIDTH = 8,
    parameter MS_CYCLES = `MS_CYCLES
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] firstMonitorParameter,
    output reg [3:0] firstMonitorSource,
    output reg [3:0] secondMonitorOutput,
    input wire servoOffRequest,
    output reg brakeInterlockOutput,
    output reg baseDriveShutoff,
    input wire [15:0] motorSpeed,
    output reg zeroSpeedOutput,
    input wire powerOnEvent,
    output reg alarmHistoryErase,
    input wire [4:0] frameStation,
    input wire frameValid,
    output reg stationMatch,
    output reg [15:0] baudDivisor,
    input wire speedMode,
    input wire undervoltage,
    input wire startInput,
    input wire alarmReset,
    output reg undervoltageAlarm,
    output reg motorRun,
    input wire largeDriveUnit,
    output reg parameterErrorAlarm,
    input wire cableFourWire,
    output reg encoderAlarmOne
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_BRAKE = 3'b010;
    localparam [2:0] ST_SHUT = 3'b100;
    localparam [31:0] DIV_0 = `CLK_HZ / `BAUD_RATE_0;
    localparam [31:0] DIV_1 = `CLK_HZ / `BAUD_RATE_1;
    localparam [31:0] DIV_2 = `CLK_HZ / `BAUD_RATE_2;
    localparam [31:0] DIV_3 = `CLK_HZ / `BAUD_RATE_3;
    localparam [31:0] DIV_4 = `CLK_HZ / `BAUD_RATE_4;

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // unknown codes fall back to motor speed so the monitor never floats
    function [3:0] decodeMonitor;
        input [15:0] code;
        begin
            if (code[15:4] == 12'h000 && code[3:0] <= `MAX_MON_CODE) begin
                decodeMonitor = code[3:0];
            end else begin
                decodeMonitor = 4'h0;
            end
        end
    endfunction

    function [15:0] mergeStrobe;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            mergeStrobe[7:0] = strb[0] ? data[7:0] : old[7:0];
            mergeStrobe[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    // out-of-range writes saturate rather than wrap
    function [15:0] clampTo;
        input [15:0] value;
        input [15:0] limit;
        begin
            clampTo = (value > limit) ? limit : value;
        end
    endfunction

    function [15:0] baudDiv;
        input [3:0] code;
        reg [31:0] div;
        begin
            case (code)
                4'h1: div = DIV_1;
                4'h2: div = DIV_2;
                4'h3: div = DIV_3;
                4'h4: div = DIV_4;
                default: div = DIV_0;
            endcase
            baudDiv = div[15:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers and bus state

    reg [15:0] secondMonitorSelect;
    reg [15:0] brakeDelayTime;
    reg [15:0] zeroSpeedThreshold;
    reg [15:0] alarmHistoryClear;
    reg [15:0] encoderOutputPulseSelect;
    reg [15:0] stationNumber;
    reg [15:0] serialCommSelect;
    reg [15:0] functionSelectOne;

    reg awHeld;
    reg [ADDR_WIDTH-1:0] awAddr;
    reg wHeld;
    reg [31:0] wData;
    reg [3:0] wStrb;
    reg [2:0] brakeState;
    reg [2:0] next_brakeState;
    reg [31:0] readValue;
    reg readHit;
    reg writeHit;

    wire doWrite;
    wire timerDone;
    wire [5:0] wIndex;
    wire [5:0] rIndex;
    wire wMapped;
    wire rMapped;
    wire restartEnable;
    wire [16:0] releaseLevel;
    wire [15:0] statusWord;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    assign wIndex = awAddr[7:2];
    assign rIndex = s_axi_araddr[7:2];
    assign wMapped = (awAddr[1:0] == 2'b00) && ((awAddr >> 8) == {ADDR_WIDTH{1'b0}})
                     && (wIndex < `REG_LAST_INDEX);
    assign rMapped = (s_axi_araddr[1:0] == 2'b00) && ((s_axi_araddr >> 8) == {ADDR_WIDTH{1'b0}})
                     && (rIndex <= `REG_LAST_INDEX);

    assign restartEnable = functionSelectOne[`RESTART_BIT];
    assign releaseLevel = {1'b0, zeroSpeedThreshold} + {1'b0, `ZSP_HYST};

    assign statusWord = {10'h000, undervoltageAlarm, encoderAlarmOne, parameterErrorAlarm,
                         baseDriveShutoff, brakeInterlockOutput, zeroSpeedOutput};

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            awHeld <= 1'b0;
            awAddr <= {ADDR_WIDTH{1'b0}};
            wHeld <= 1'b0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wMapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parameter registers

    always @* begin
        writeHit = doWrite && wMapped;
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            secondMonitorSelect <= `RST_MON2_SEL;
            brakeDelayTime <= `RST_BRAKE_DLY;
            zeroSpeedThreshold <= `RST_ZSP_THR;
            alarmHistoryClear <= `RST_HIST_CLR;
            encoderOutputPulseSelect <= `RST_ENC_PULSE;
            stationNumber <= `RST_STATION;
            serialCommSelect <= `RST_COMM_SEL;
            functionSelectOne <= `RST_FUNC_SEL1;
            alarmHistoryErase <= 1'b0;
        end else begin
            alarmHistoryErase <= 1'b0;
            // erase waits for the next power-on, then the field drops itself
            if (powerOnEvent && alarmHistoryClear[`HIST_CLR_BIT]) begin
                alarmHistoryErase <= 1'b1;
                alarmHistoryClear <= 16'h0000;
            end
            if (writeHit) begin
                case ({wIndex, 2'b00})
                    `OFS_MON2_SEL:
                        secondMonitorSelect <= mergeStrobe(secondMonitorSelect, wData, wStrb);
                    `OFS_BRAKE_DLY:
                        brakeDelayTime <= clampTo(mergeStrobe(brakeDelayTime, wData, wStrb),
                                                  `MAX_BRAKE_DLY);
                    `OFS_ZSP_THR:
                        zeroSpeedThreshold <= clampTo(
                            mergeStrobe(zeroSpeedThreshold, wData, wStrb),
                            `MAX_ZSP_THR);
                    // a host write on the erase edge wins, so a fresh request survives
                    `OFS_HIST_CLR:
                        alarmHistoryClear <= mergeStrobe(alarmHistoryClear, wData, wStrb);
                    `OFS_ENC_PULSE:
                        encoderOutputPulseSelect <= mergeStrobe(encoderOutputPulseSelect,
                                                                wData, wStrb);
                    `OFS_STATION:
                        stationNumber <= clampTo(mergeStrobe(stationNumber, wData, wStrb),
                                                 `MAX_STATION);
                    `OFS_COMM_SEL:
                        serialCommSelect <= mergeStrobe(serialCommSelect, wData, wStrb);
                    `OFS_FUNC_SEL1:
                        functionSelectOne <= mergeStrobe(functionSelectOne, wData, wStrb);
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    always @* begin
        readValue = 32'h0000_0000;
        readHit = rMapped;
        case ({rIndex, 2'b00})
            `OFS_MON2_SEL: readValue[15:0] = secondMonitorSelect;
            `OFS_BRAKE_DLY: readValue[15:0] = brakeDelayTime;
            `OFS_ZSP_THR: readValue[15:0] = zeroSpeedThreshold;
            `OFS_HIST_CLR: readValue[15:0] = alarmHistoryClear;
            `OFS_ENC_PULSE: readValue[15:0] = encoderOutputPulseSelect;
            `OFS_STATION: readValue[15:0] = stationNumber;
            `OFS_COMM_SEL: readValue[15:0] = serialCommSelect;
            `OFS_FUNC_SEL1: readValue[15:0] = functionSelectOne;
            `OFS_STATUS: readValue[15:0] = statusWord;
            default: readValue = 32'h0000_0000;
        endcase
        if (!rMapped) begin
            readValue = 32'h0000_0000;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readValue;
            s_axi_rresp <= readHit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // brake sequence

    ms_delay_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) brakeTimer (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(brakeState == ST_BRAKE),
        .delayMs(brakeDelayTime),
        .done(timerDone)
    );

    always @* begin
        case (brakeState)
            ST_IDLE: next_brakeState = servoOffRequest ? ST_BRAKE : ST_IDLE;
            ST_BRAKE: begin
                if (!servoOffRequest) begin
                    next_brakeState = ST_IDLE;
                end else if (timerDone) begin
                    next_brakeState = ST_SHUT;
                end else begin
                    next_brakeState = ST_BRAKE;
                end
            end
            ST_SHUT: next_brakeState = servoOffRequest ? ST_SHUT : ST_IDLE;
            default: next_brakeState = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            brakeState <= ST_IDLE;
            brakeInterlockOutput <= 1'b0;
            baseDriveShutoff <= 1'b0;
        end else begin
            brakeState <= next_brakeState;
            // brake engages first; the power stage drops only after the delay
            brakeInterlockOutput <= (next_brakeState != ST_IDLE);
            baseDriveShutoff <= (next_brakeState == ST_SHUT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // zero speed, station match, monitors, baud rate

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            zeroSpeedOutput <= 1'b0;
            stationMatch <= 1'b0;
            firstMonitorSource <= 4'h0;
            secondMonitorOutput <= 4'h1;
            baudDivisor <= 16'h0000;
        end else begin
            // hysteresis keeps the output steady while speed hovers at the edge
            if (motorSpeed <= zeroSpeedThreshold) begin
                zeroSpeedOutput <= 1'b1;
            end else if ({1'b0, motorSpeed} > releaseLevel) begin
                zeroSpeedOutput <= 1'b0;
            end
            stationMatch <= frameValid && ({11'h000, frameStation} == stationNumber);
            firstMonitorSource <= decodeMonitor(firstMonitorParameter);
            secondMonitorOutput <= decodeMonitor(secondMonitorSelect);
            baudDivisor <= baudDiv(serialCommSelect[`BAUD_LSB+3:`BAUD_LSB]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // undervoltage restart and alarms

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            undervoltageAlarm <= 1'b0;
            motorRun <= 1'b0;
            parameterErrorAlarm <= 1'b0;
            encoderAlarmOne <= 1'b0;
        end else begin
            if (undervoltage) begin
                undervoltageAlarm <= 1'b1;
            end else if (alarmReset) begin
                undervoltageAlarm <= 1'b0;
            end else if (restartEnable && speedMode && startInput) begin
                undervoltageAlarm <= 1'b0;
            end
            motorRun <= startInput && !undervoltage && !undervoltageAlarm
                        && !parameterErrorAlarm && !encoderAlarmOne;
            parameterErrorAlarm <= restartEnable && largeDriveUnit;
            // only code 1 means four-wire; any other value means two-wire
            encoderAlarmOne <= ((functionSelectOne[`CABLE_LSB+3:`CABLE_LSB] == 4'h1)
                                != cableFourWire);
        end
    end
endmodule

// [hdl/servo_param_defs.vh]
// constants for the servo configuration parameter bank
`ifndef SERVO_PARAM_DEFS_VH
`define SERVO_PARAM_DEFS_VH

// register byte offsets
`define OFS_MON2_SEL 8'h00
`define OFS_BRAKE_DLY 8'h04
`define OFS_ZSP_THR 8'h08
`define OFS_HIST_CLR 8'h0C
`define OFS_ENC_PULSE 8'h10
`define OFS_STATION 8'h14
`define OFS_COMM_SEL 8'h18
`define OFS_FUNC_SEL1 8'h1C
`define OFS_STATUS 8'h20
`define REG_LAST_INDEX 6'h08

// reset values
`define RST_MON2_SEL 16'h0001
`define RST_BRAKE_DLY 16'h0064
`define RST_ZSP_THR 16'h0032
`define RST_HIST_CLR 16'h0000
`define RST_ENC_PULSE 16'h0000
`define RST_STATION 16'h0000
`define RST_COMM_SEL 16'h0000
`define RST_FUNC_SEL1 16'h0000

// setting limits
`define MAX_BRAKE_DLY 16'h03E8
`define MAX_ZSP_THR 16'h2710
`define MAX_STATION 16'h001F
`define ZSP_HYST 16'h0014
`define MAX_MON_CODE 4'hD

// field positions
`define HIST_CLR_BIT 0
`define RESTART_BIT 0
`define CABLE_LSB 8
`define BAUD_LSB 0

// status register bits
`define ST_ZSP 0
`define ST_BRAKE 1
`define ST_SHUTOFF 2
`define ST_PARAM_ERR 3
`define ST_ENC_ALM 4
`define ST_UV_ALM 5

// timing
`define CLK_HZ 100000000
`define TIME_MS_NS 1000000
`define CLK_PERIOD_NS 10
`define MS_CYCLES (`TIME_MS_NS / `CLK_PERIOD_NS)
`define BAUD_RATE_0 9600
`define BAUD_RATE_1 19200
`define BAUD_RATE_2 38400
`define BAUD_RATE_3 57600
`define BAUD_RATE_4 115200

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [sim/host_link_model.sv]
// host controller model that hands over station addresses of received frames
`timescale 1ns/100ps
module host_link_model (
    input logic sys_clk,
    output logic [4:0] frameStation,
    output logic frameValid
);
initial begin
    frameStation = 5'h1F;
    frameValid = 1'b0;
end
// each axis is addressed by its own number only; idle lines show no stale address
task send(input [4:0] st);
    begin
        @(posedge sys_clk);
        frameStation <= st;
        frameValid <= 1'b1;
        @(posedge sys_clk);
        frameStation <= ~st;
        frameValid <= 1'b0;
    end
endtask
endmodule

// [sim/servo_bank_checker_assertions.sv]
// port checker for the servo parameter bank
`timescale 1ns/100ps
module servo_bank_checker (
    input logic sys_clk,
    input logic rst_b,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic servoOffRequest,
    input logic brakeInterlockOutput,
    input logic baseDriveShutoff,
    input logic powerOnEvent,
    input logic alarmHistoryErase,
    input logic frameValid,
    input logic stationMatch,
    input logic [15:0] baudDivisor
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_b);
////////////////////////////////////////////////////////////////////////////////
a_brake_on: assert property (servoOffRequest |=> brakeInterlockOutput)
    else $error("brake output missing after request");
a_brake_off: assert property (!servoOffRequest |=> !brakeInterlockOutput && !baseDriveShutoff)
    else $error("brake sequence did not end");
a_shutoff_after: assert property (baseDriveShutoff |-> $past(brakeInterlockOutput))
    else $error("power stage cut before brake");
a_erase_pulse: assert property (alarmHistoryErase |-> $past(powerOnEvent) ##1 !alarmHistoryErase)
    else $error("history erase without power-on");
a_match_cause: assert property (stationMatch |-> $past(frameValid))
    else $error("station match without frame");
a_baud_legal: assert property ($past(rst_b) |-> baudDivisor inside
    {16'h28B0, 16'h1458, 16'h0A2C, 16'h06C8, 16'h0364})
    else $error("illegal baud divisor");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
a_write_turn: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
c_shutoff: cover property ($rose(baseDriveShutoff));
c_erase: cover property (alarmHistoryErase);
c_match: cover property (stationMatch);
endmodule
bind servo_config_parameter_bank servo_bank_checker chk_i (.sys_clk, .rst_b, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .servoOffRequest, .brakeInterlockOutput, .baseDriveShutoff, .powerOnEvent,
    .alarmHistoryErase, .frameValid, .stationMatch, .baudDivisor);

// [sim/servo_config_parameter_bank_tb.sv]
// self-checking bench for the servo parameter bank
`timescale 1ns/100ps
`include "servo_param_defs.vh"
module servo_config_parameter_bank_tb;
logic sys_clk = 1'b0;
logic rst_b = 1'b0;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic [31:0] s_axi_wdata = 32'h0000_0000;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
logic [15:0] firstMonitorParameter = 16'h0000, motorSpeed = 16'h0000;
logic servoOffRequest = 1'b0, powerOnEvent = 1'b0, speedMode = 1'b0, undervoltage = 1'b0;
logic startInput = 1'b0, largeDriveUnit = 1'b0, cableFourWire = 1'b0;
wire [4:0] frameStation;
wire frameValid;
wire [3:0] firstMonitorSource, secondMonitorOutput;
wire brakeInterlockOutput, baseDriveShutoff, zeroSpeedOutput, alarmHistoryErase, stationMatch;
wire undervoltageAlarm, motorRun, parameterErrorAlarm, encoderAlarmOne;
wire [15:0] baudDivisor;
integer error_cnt = 0, n_tests = 0, i, k;
logic [31:0] got;
logic [1:0] resp;
logic [15:0] rstVal [0:7] = '{16'h0001, 16'h0064, 16'h0032, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000};
logic [15:0] spd [0:4] = '{16'h0064, 16'h0078, 16'h0079, 16'h0065, 16'h0064};
logic zExp [0:4] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
integer rate [0:5] = '{`BAUD_RATE_0, `BAUD_RATE_1, `BAUD_RATE_2, `BAUD_RATE_3, `BAUD_RATE_4,
    `BAUD_RATE_0};
always #5 sys_clk = ~sys_clk;
// short millisecond so the brake delay stays a few dozen cycles
servo_config_parameter_bank #(.MS_CYCLES(10)) uut (.sys_clk, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .firstMonitorParameter, .firstMonitorSource, .secondMonitorOutput, .servoOffRequest,
    .brakeInterlockOutput, .baseDriveShutoff, .motorSpeed, .zeroSpeedOutput, .powerOnEvent,
    .alarmHistoryErase, .frameStation, .frameValid, .stationMatch, .baudDivisor, .speedMode,
    .undervoltage, .startInput, .alarmReset(1'b0), .undervoltageAlarm, .motorRun,
    .largeDriveUnit, .parameterErrorAlarm, .cableFourWire, .encoderAlarmOne);
host_link_model host (.sys_clk, .frameStation, .frameValid);
////////////////////////////////////////////////////////////////////////////////
task end_of_test;
    begin
        if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    end
endtask
task chk(input [31:0] g, input [31:0] e);
    begin
        n_tests = n_tests + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    end
endtask
task nx(input integer n);
    begin
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    end
endtask
// handshakes are judged at the falling edge, so the taking edge is the next rising one
task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    logic ta, tw, tb;
    integer n;
    begin
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        tb = 1'b0;
        while (!tb) begin
            @(negedge sys_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n = n + 1;
            if (n > 50) begin
                error_cnt = error_cnt + 1;
                end_of_test;
            end
        end
        s_axi_bready <= 1'b0;
        chk(resp, er);
    end
endtask
task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    logic ta, tr;
    integer n;
    begin
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        tr = 1'b0;
        while (!tr) begin
            @(negedge sys_clk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            got = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge sys_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            n = n + 1;
            if (n > 50) begin
                error_cnt = error_cnt + 1;
                end_of_test;
            end
        end
        s_axi_rready <= 1'b0;
        chk(got, e);
        chk(resp, er);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
        rd(8'(i * 4), rstVal[i], 2'b00);
    chk(baudDivisor, `CLK_HZ / rate[0]);
    rd(8'h24, 32'h0000_0000, 2'b10);
    wr(8'h20, 32'h0000_0001, 2'b10);
    for (i = 0; i < 15; i = i + 1) begin
        firstMonitorParameter <= 16'(i);
        wr(8'h00, i, 2'b00);
        nx(2);
        chk(secondMonitorOutput, i < 14 ? i : 0);
        chk(firstMonitorSource, i < 14 ? i : 0);
    end
    wr(8'h04, 32'h0000_07FF, 2'b00);
    rd(8'h04, 32'h0000_03E8, 2'b00);
    wr(8'h04, 32'h0000_0003, 2'b00);
    servoOffRequest <= 1'b1;
    for (k = 0; k < 60 && baseDriveShutoff !== 1'b1; k = k + 1)
        @(negedge sys_clk);
    chk(k >= 31 && k <= 36, 1);
    chk(brakeInterlockOutput, 1);
    @(posedge sys_clk);
    servoOffRequest <= 1'b0;
    nx(2);
    chk({brakeInterlockOutput, baseDriveShutoff}, 0);
    wr(8'h08, 32'h0000_FFFF, 2'b00);
    rd(8'h08, 32'h0000_2710, 2'b00);
    wr(8'h08, 32'h0000_0064, 2'b00);
    for (i = 0; i < 5; i = i + 1) begin
        @(posedge sys_clk);
        motorSpeed <= spd[i];
        nx(2);
        chk(zeroSpeedOutput, zExp[i]);
    end
    wr(8'h0C, 32'h0000_0001, 2'b00);
    nx(3);
    chk(alarmHistoryErase, 0);
    for (i = 0; i < 2; i = i + 1) begin
        @(posedge sys_clk);
        powerOnEvent <= 1'b1;
        @(posedge sys_clk);
        powerOnEvent <= 1'b0;
        @(negedge sys_clk);
        chk(alarmHistoryErase, i == 0);
        rd(8'h0C, 32'h0000_0000, 2'b00);
    end
    wr(8'h14, 32'h0000_0028, 2'b00);
    rd(8'h14, 32'h0000_001F, 2'b00);
    wr(8'h14, 32'h0000_0005, 2'b00);
    for (i = 5; i < 7; i = i + 1) begin
        host.send(5'(i));
        @(negedge sys_clk);
        chk(stationMatch, i == 5);
    end
    for (i = 0; i < 6; i = i + 1) begin
        wr(8'h18, i, 2'b00);
        nx(2);
        chk(baudDivisor, `CLK_HZ / rate[i]);
    end
    speedMode <= 1'b1;
    undervoltage <= 1'b1;
    nx(2);
    chk(undervoltageAlarm, 1);
    @(posedge sys_clk);
    undervoltage <= 1'b0;
    startInput <= 1'b1;
    nx(2);
    chk({undervoltageAlarm, motorRun}, 2'b10);
    wr(8'h1C, 32'h0000_0001, 2'b00);
    nx(2);
    chk({undervoltageAlarm, motorRun}, 2'b01);
    @(posedge sys_clk);
    largeDriveUnit <= 1'b1;
    nx(2);
    chk(parameterErrorAlarm, 1);
    wr(8'h1C, 32'h0000_0100, 2'b00);
    nx(2);
    chk({parameterErrorAlarm, encoderAlarmOne}, 2'b01);
    @(posedge sys_clk);
    cableFourWire <= 1'b1;
    nx(2);
    chk(encoderAlarmOne, 0);
    wr(8'h1C, 32'h0000_0200, 2'b00);
    nx(2);
    chk(encoderAlarmOne, 1);
    rd(8'h20, 32'h0000_0011, 2'b00);
    end_of_test;
end
endmodule
